/* File: tb_vrc_host.sv */
`timescale 1ns/1ps
module tb_vrc_host
  import vrc_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic e;
  vrc_dram_pins_t dram_pins;
  logic serial_shift_clock, serial_output_enable_n, active_half_flag;
  logic [15:0] serial_data;
  int fails = 0, checks_done = 0, cyc = 0;
  initial forever #50 pclk = ~pclk;
  vrc_host vrc_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .dram_pins, .serial_shift_clock, .serial_output_enable_n,
    .serial_data, .active_half_flag);
  vrc_vram_model vrc_vram_model_i (.dram_pins, .serial_shift_clock, .serial_output_enable_n,
    .serial_data, .active_half_flag);
  task automatic end_sim;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      end_sim();
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : bus
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x)
    begin
      $display("mismatch %s expected %h seen %h", n, x, g);
      fails++;
    end
  endtask : chk
  task automatic wait_done;
    for (int k = 0; k < 2000; k++)
    begin
      bus(0, OFS_STATUS, 0);
      if (r[ST_BUSY] === 1'b0 && r[31:16] === 16'h0) break;
    end
    repeat (10) @(posedge pclk);
  endtask : wait_done
  task automatic cmd(input logic [8:0] rw, input logic [8:0] cl, input logic [31:0] c);
    bus(1, OFS_ROW, {23'h0, rw});
    bus(1, OFS_COL, {23'h0, cl});
    bus(1, OFS_CTRL, c);
    wait_done();
  endtask : cmd
  task automatic shift_rd(input logic [15:0] n, input logic [15:0] w);
    bus(1, OFS_SHIFT, {16'h0, n});
    wait_done();
    bus(0, OFS_DATA, 0);
    chk("data", {16'h0, w}, r);
  endtask : shift_rd
  task automatic stat(input string n, input logic [31:0] m, input logic [31:0] x);
    bus(0, OFS_STATUS, 0);
    chk(n, x, r & m);
    bus(1, OFS_STATUS, 32'h30);
  endtask : stat
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    stat("status", 32'hffff_ffff, 32'h0);
    bus(0, OFS_PART, 0);
    chk("part", 32'h7, r);
    bus(0, 8'h1c, 0);
    chk("slverr", 32'h1, {31'h0, e});
    cmd(9'h005, 9'h17e, 32'h12);
    stat("refused", 32'h10, 32'h10);
    cmd(9'h005, 9'h17e, 32'h11);
    stat("init", 32'hffff_ffff, 32'h4a);
    shift_rd(0, 16'h0b7f);
    cmd(9'h003, 9'h0ff, 32'h11);
    shift_rd(2, 16'h0600);
    stat("flag", 32'h40, 32'h0);
    cmd(9'h009, 9'h17f, 32'h12);
    stat("badtap", 32'h20, 32'h20);
    cmd(9'h009, 9'h110, 32'h12);
    shift_rd(128, 16'h1390);
    stat("half", 32'h40, 32'h40);
    bus(1, OFS_CTRL, 32'h10);
    repeat (2) @(posedge pclk);
    chk("oe_on", 32'h0, {31'h0, serial_output_enable_n});
    bus(1, OFS_CTRL, 32'h0);
    repeat (2) @(posedge pclk);
    chk("oe", 32'h1, {31'h0, serial_output_enable_n});
    bus(1, OFS_SHIFT, 32'd111);
    wait_done();
    bus(1, OFS_CTRL, 32'h10);
    shift_rd(1, 16'h0600);
    bus(1, OFS_PART, 32'h1);
    cmd(9'h000, 9'h000, 32'h13);
    stat("stop", 32'h4, 32'h4);
    cmd(9'h006, 9'h105, 32'h12);
    shift_rd(32, 16'h0d85);
    cmd(9'h006, 9'h01f, 32'h12);
    stat("stoptap", 32'h20, 32'h20);
    end_sim();
  end
endmodule : tb_vrc_host

/* File: vrc_host.sv */
// Contract
// [RULE_01] transfer: gate low, write enables high, row fall
// [RULE_02] function select low full, high split
// [RULE_03] either write enable low means write
// [RULE_04] full: row 9 bits, A8 half, A0-A7 tap
// [RULE_05] gate trailing edge early, mid or late
// [RULE_06] split halves 0-127 and 128-255
// [RULE_07] split ignores A7, loads inactive half
// [RULE_08] never tap 127, 255 or stop points; code rejects these for split transfers only, full transfers accept any tap
// [RULE_09] full transfer before first split transfer
// [RULE_10] half flag low lower, high upper
// [RULE_11] half flag follows full tap, toggles crossing
// [RULE_12] serial reads independent except during transfer
// [RULE_13] word per rising clock, enable low drives
// [RULE_14] counter advances regardless of output enable
// [RULE_15] full: tap up to 255, wrap 0
// [RULE_16] split: to half top, jump to new tap
// [RULE_17] no new split: continue other half start
// [RULE_18] stop mode: partitions end in stop points
// [RULE_19] set cycle: column, write low, select high
// [RULE_20] partition codes 16, 32, 64, 128 default
// [RULE_21] stop mode off until set cycle
// [RULE_22] split tap picks starting partition
// [RULE_23] stop mode swaps column bits seven, eight
// [RULE_24] column-before-row cycle ends stop mode; code issues none, stop mode holds until reset
// [RULE_25] init: full transfer then two serial clocks
// [RULE_26] transfer loads counter with tap point
`timescale 1ns/1ps
module vrc_host
  import vrc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output vrc_dram_pins_t dram_pins,
  output logic serial_shift_clock,
  output logic serial_output_enable_n,
  input wire logic [15:0] serial_data,
  input wire logic active_half_flag
);

  vrc_state_t state_q;
  vrc_state_t state_d;
  vrc_cmd_t cmd_q;
  vrc_dram_pins_t pins_d;
  logic pend_q;
  logic [8:0] row_q;
  logic [8:0] col_q;
  logic [3:0] part_q;
  logic oe_q;
  logic full_done_q;
  logic stop_mode_q;
  logic init_done_q;
  logic refused_q;
  logic bad_tap_q;
  logic [15:0] shift_left_q;
  logic [15:0] last_word_q;
  logic [2:0] div_q;
  logic sc_q;
  logic [16:0] pins_sync;
  logic [15:0] data_s;
  logic half_s;
  logic access;
  logic wr;
  logic mapped;
  logic [31:0] rdata_d;
  logic [1:0] wcmd;
  logic cmd_wr;
  logic tap_bad;
  logic cmd_ok;
  logic [6:0] part_mask;
  logic [6:0] tap_mask;
  logic [8:0] col_split;
  logic [8:0] col_eff;
  logic xfer_hold;
  logic sc_run;
  logic sc_tick;
  logic sc_fall;
  logic done;

  vrc_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({active_half_flag, serial_data}),
    .sync_out(pins_sync)
  );

  assign data_s = pins_sync[15:0];
  assign half_s = pins_sync[16]; // see [RULE_10]

  // apb slave, one wait state
  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_ROW) || (paddr == OFS_COL) ||
                  (paddr == OFS_SHIFT) || (paddr == OFS_STATUS) || (paddr == OFS_DATA) ||
                  (paddr == OFS_PART);

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL: rdata_d[CTRL_OE_BIT] = oe_q;
      OFS_ROW: rdata_d[8:0] = row_q;
      OFS_COL: rdata_d[8:0] = col_q;
      OFS_SHIFT: rdata_d[15:0] = shift_left_q;
      OFS_STATUS:
      begin
        rdata_d[ST_BUSY] = pend_q || (state_q != ST_IDLE);
        rdata_d[ST_FULL_DONE] = full_done_q;
        rdata_d[ST_STOP_MODE] = stop_mode_q;
        rdata_d[ST_INIT_DONE] = init_done_q;
        rdata_d[ST_REFUSED] = refused_q;
        rdata_d[ST_BAD_TAP] = bad_tap_q;
        rdata_d[ST_HALF_FLAG] = half_s; // see [RULE_11]
        rdata_d[ST_SHIFT_LSB +: 16] = shift_left_q;
      end
      OFS_DATA: rdata_d[15:0] = last_word_q;
      OFS_PART: rdata_d[3:0] = part_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite)
        prdata <= rdata_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      row_q <= ROW_RESET;
      col_q <= COL_RESET;
      part_q <= PART_RESET; // see [RULE_20]
      oe_q <= 1'b0;
    end
    else if (wr)
    begin
      if (paddr == OFS_ROW)
        row_q <= pwdata[8:0];
      if (paddr == OFS_COL)
        col_q <= pwdata[8:0];
      if (paddr == OFS_PART)
        part_q <= pwdata[3:0];
      if (paddr == OFS_CTRL)
        oe_q <= pwdata[CTRL_OE_BIT];
    end
  end

  // partition mask of the stop points
  always_comb
  begin
    unique case (part_q)
      PART_LEN16: part_mask = MASK_LEN16;
      PART_LEN32: part_mask = MASK_LEN32;
      PART_LEN64: part_mask = MASK_LEN64;
      default: part_mask = MASK_LEN128; // see [RULE_20]
    endcase
  end

  assign tap_mask = stop_mode_q ? part_mask : MASK_LEN128; // see [RULE_18]
  assign tap_bad = (col_q[6:0] & tap_mask) == tap_mask; // see [RULE_08]

  assign wcmd = pwdata[1:0];
  assign cmd_wr = wr && (paddr == OFS_CTRL) && (wcmd != CMD_NONE);
  assign cmd_ok = !pend_q && (state_q == ST_IDLE) &&
                  !((wcmd == CMD_SPLIT) && (!full_done_q || tap_bad)); // see [RULE_09]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_q <= 1'b0;
      cmd_q <= CMD_NONE;
    end
    else if (cmd_wr && cmd_ok)
    begin
      pend_q <= 1'b1;
      cmd_q <= vrc_cmd_t'(wcmd);
    end
    else if (state_q == ST_SETUP)
      pend_q <= 1'b0;
  end

  // error flags: set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      refused_q <= 1'b0;
      bad_tap_q <= 1'b0;
    end
    else
    begin
      if (cmd_wr && !cmd_ok)
        refused_q <= 1'b1;
      else if (wr && (paddr == OFS_STATUS) && pwdata[ST_REFUSED])
        refused_q <= 1'b0;
      if (cmd_wr && (wcmd == CMD_SPLIT) && tap_bad)
        bad_tap_q <= 1'b1; // see [RULE_08]
      else if (wr && (paddr == OFS_STATUS) && pwdata[ST_BAD_TAP])
        bad_tap_q <= 1'b0;
    end
  end

  // strobe sequencer; starts only with serial clock parked low
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
        if (pend_q && !sc_q)
          state_d = ST_SETUP; // see [RULE_12]
      ST_SETUP: state_d = ST_ROW;
      ST_ROW: state_d = (cmd_q == CMD_STOP_SET) ? ST_END : ST_COL;
      ST_COL: state_d = ST_CASF;
      ST_CASF: state_d = ST_TRGR;
      ST_TRGR: state_d = ST_END;
      ST_END: state_d = ST_PRE;
      ST_PRE: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  assign col_split = {col_q[8], 1'b0, col_q[6:0]}; // see [RULE_07]
  // stop mode swaps the two top column bits
  assign col_eff = stop_mode_q ?
                   {((cmd_q == CMD_SPLIT) ? col_split[7] : col_q[7]), col_q[8], col_q[6:0]} :
                   ((cmd_q == CMD_SPLIT) ? col_split : col_q); // see [RULE_23]

  always_comb
  begin
    pins_d = dram_pins;
    unique case (state_d)
      ST_IDLE, ST_PRE: pins_d = PINS_IDLE;
      ST_SETUP:
      begin
        pins_d = PINS_IDLE;
        if (cmd_q == CMD_STOP_SET)
        begin
          pins_d.column_strobe_n = 1'b0; // see [RULE_19]
          pins_d.low_byte_write_enable_n = 1'b0; // see [RULE_03]
          pins_d.high_byte_write_enable_n = 1'b0;
          pins_d.function_select = 1'b1;
          pins_d.addr = {1'b0, part_q, 4'h0};
        end
        else
        begin
          pins_d.transfer_gate_n = 1'b0; // see [RULE_01]
          pins_d.function_select = (cmd_q == CMD_SPLIT); // see [RULE_02]
          pins_d.addr = row_q; // see [RULE_04]
        end
      end
      ST_ROW: pins_d.row_strobe_n = 1'b0;
      ST_COL:
      begin
        pins_d.function_select = 1'b0;
        pins_d.addr = col_eff; // see [RULE_26]
      end
      ST_CASF: pins_d.column_strobe_n = 1'b0;
      ST_TRGR: pins_d.transfer_gate_n = 1'b1; // see [RULE_05]
      ST_END: pins_d = PINS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dram_pins <= PINS_IDLE;
    else
      dram_pins <= pins_d;
  end

  assign done = (state_q == ST_PRE);

  // mode and init bookkeeping; no column-before-row cycle but the stop set is issued
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      full_done_q <= 1'b0;
      stop_mode_q <= 1'b0; // see [RULE_21]
    end
    else if (done)
    begin
      if (cmd_q == CMD_FULL)
        full_done_q <= 1'b1;
      if (cmd_q == CMD_STOP_SET)
        stop_mode_q <= 1'b1; // see [RULE_21]
    end
  end

  // serial clock divider, held low during a transfer
  assign xfer_hold = pend_q || (state_q != ST_IDLE);
  assign sc_run = (shift_left_q != 16'h0000) && (sc_q || !xfer_hold);
  assign sc_tick = sc_run && (div_q == SC_HALF_LAST);
  assign sc_fall = sc_tick && sc_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q <= 3'h0;
      sc_q <= 1'b0;
    end
    else if (sc_tick)
    begin
      div_q <= 3'h0;
      sc_q <= !sc_q; // see [RULE_14]
    end
    else if (sc_run)
      div_q <= div_q + 3'h1;
    else
      div_q <= 3'h0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_left_q <= 16'h0000;
      init_done_q <= 1'b0;
    end
    else if (wr && (paddr == OFS_SHIFT))
      shift_left_q <= pwdata[15:0];
    else if (done && (cmd_q == CMD_FULL) && !init_done_q)
    begin
      shift_left_q <= shift_left_q + INIT_SHIFTS; // see [RULE_25]
      init_done_q <= 1'b1;
    end
    else if (sc_fall)
      shift_left_q <= shift_left_q - 16'h0001;
  end

  // word presented after the rising edge, taken before the next one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_word_q <= 16'h0000;
    else if (sc_fall)
      last_word_q <= data_s; // see [RULE_13]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_shift_clock <= 1'b0;
      serial_output_enable_n <= 1'b1;
    end
    else
    begin
      serial_shift_clock <= sc_tick ? !sc_q : sc_q;
      serial_output_enable_n <= !oe_q; // see [RULE_13]
    end
  end

endmodule : vrc_host

/* File: vrc_host_props.sv */
`timescale 1ns/1ps
module vrc_host_props
  import vrc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire vrc_dram_pins_t dram_pins,
  input wire logic serial_shift_clock
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire vrc_dram_pins_t p = dram_pins;
  property p_ans;
    psel && penable && !pready |=> pready;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer after one wait state");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready held too long");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_acc;
    pready |-> psel && penable;
  endproperty
  a_acc: assert property (p_acc) else $error("pready outside access phase");
  property p_xfer;
    $fell(p.row_strobe_n) && !p.transfer_gate_n |-> p.column_strobe_n &&
      p.low_byte_write_enable_n && p.high_byte_write_enable_n;
  endproperty
  a_xfer: assert property (p_xfer) else $error("bad transfer request");
  property p_set;
    $fell(p.row_strobe_n) && p.transfer_gate_n |-> !p.column_strobe_n &&
      p.function_select && !p.low_byte_write_enable_n && p.addr[3:0] == 4'h0;
  endproperty
  a_set: assert property (p_set) else $error("bad set cycle");
  property p_col;
    $fell(p.column_strobe_n) && !p.transfer_gate_n |-> !p.row_strobe_n &&
      $past(p.row_strobe_n, 1) == 1'b0 && !p.function_select;
  endproperty
  a_col: assert property (p_col) else $error("column before row");
  property p_gate;
    $fell(p.column_strobe_n) && !p.transfer_gate_n |=> p.transfer_gate_n;
  endproperty
  a_gate: assert property (p_gate) else $error("gate not released");
  property p_halt;
    !p.transfer_gate_n |-> !serial_shift_clock;
  endproperty
  a_halt: assert property (p_halt) else $error("serial clock in transfer");
  property p_sc;
    $rose(serial_shift_clock) |-> serial_shift_clock[*4] ##1 !serial_shift_clock;
  endproperty
  a_sc: assert property (p_sc) else $error("serial clock high phase");
  c_full: cover property ($fell(p.row_strobe_n) && !p.transfer_gate_n && !p.function_select);
  c_split: cover property ($fell(p.row_strobe_n) && !p.transfer_gate_n && p.function_select);
  c_set: cover property ($fell(p.row_strobe_n) && p.transfer_gate_n);
  c_err: cover property (pslverr);
endmodule : vrc_host_props
bind vrc_host vrc_host_props vrc_host_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .dram_pins(dram_pins),
  .serial_shift_clock(serial_shift_clock));

/* File: vrc_pkg.sv */
package vrc_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int SC_HALF_NS = 400;
  localparam int SC_HALF_CYC = (SC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SC_HALF_LAST = 3'(SC_HALF_CYC - 1);

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ROW = 8'h04;
  localparam logic [7:0] OFS_COL = 8'h08;
  localparam logic [7:0] OFS_SHIFT = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_DATA = 8'h14;
  localparam logic [7:0] OFS_PART = 8'h18;

  localparam int CTRL_OE_BIT = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_FULL_DONE = 1;
  localparam int ST_STOP_MODE = 2;
  localparam int ST_INIT_DONE = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_BAD_TAP = 5;
  localparam int ST_HALF_FLAG = 6;
  localparam int ST_SHIFT_LSB = 16;

  localparam logic [3:0] PART_LEN16 = 4'h0;
  localparam logic [3:0] PART_LEN32 = 4'h1;
  localparam logic [3:0] PART_LEN64 = 4'h3;
  localparam logic [3:0] PART_LEN128 = 4'h7;
  localparam logic [3:0] PART_RESET = PART_LEN128;
  localparam logic [6:0] MASK_LEN16 = 7'h0f;
  localparam logic [6:0] MASK_LEN32 = 7'h1f;
  localparam logic [6:0] MASK_LEN64 = 7'h3f;
  localparam logic [6:0] MASK_LEN128 = 7'h7f;

  localparam logic [15:0] INIT_SHIFTS = 16'h0002;
  localparam logic [8:0] ROW_RESET = 9'h000;
  localparam logic [8:0] COL_RESET = 9'h000;

  typedef enum logic [1:0] {
    CMD_NONE = 2'h0,
    CMD_FULL = 2'h1,
    CMD_SPLIT = 2'h2,
    CMD_STOP_SET = 2'h3
  } vrc_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_ROW = 3'b011,
    ST_COL = 3'b010,
    ST_CASF = 3'b110,
    ST_TRGR = 3'b111,
    ST_END = 3'b101,
    ST_PRE = 3'b100
  } vrc_state_t;

  typedef struct packed {
    logic row_strobe_n;
    logic column_strobe_n;
    logic transfer_gate_n;
    logic low_byte_write_enable_n;
    logic high_byte_write_enable_n;
    logic function_select;
    logic [8:0] addr;
  } vrc_dram_pins_t;

  localparam vrc_dram_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 9'h000};

endpackage : vrc_pkg

/* File: vrc_sync.sv */
`timescale 1ns/1ps
module vrc_sync
  import vrc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [16:0] async_in,
  output logic [16:0] sync_out
);

  logic [16:0] meta_q;

  generate
    for (genvar i = 0; i < 17; i++)
    begin : g_bit
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta_q[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta_q[i] <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule : vrc_sync

/* File: vrc_vram_model.sv */
`timescale 1ns/1ps
module vrc_vram_model
  import vrc_pkg::*;
(
  input wire vrc_dram_pins_t dram_pins,
  input wire logic serial_shift_clock,
  input wire logic serial_output_enable_n,
  output logic [15:0] serial_data,
  output logic active_half_flag
);
  logic [15:0] serial_access_memory [256];
  logic [8:0] row;
  logic [8:0] a;
  logic [7:0] ptr = 8'h00;
  logic [7:0] nxt;
  logic [6:0] mask = 7'h7f;
  logic [15:0] q = 16'h0000;
  logic xfer, split, h;
  logic stop = 1'b0;
  logic pend = 1'b0;
  int i;
  always @(negedge dram_pins.row_strobe_n)
  begin
    row = dram_pins.addr;
    xfer = !dram_pins.transfer_gate_n && dram_pins.low_byte_write_enable_n &&
      dram_pins.high_byte_write_enable_n;
    split = dram_pins.function_select;
    if (!dram_pins.column_strobe_n && split && !(dram_pins.low_byte_write_enable_n &&
      dram_pins.high_byte_write_enable_n))
    begin
      stop = 1'b1;
      case (row[7:4])
        4'h0: mask = 7'h0f;
        4'h1: mask = 7'h1f;
        4'h3: mask = 7'h3f;
        default: mask = 7'h7f;
      endcase
    end
  end
  always @(negedge dram_pins.column_strobe_n)
  begin
    a = dram_pins.addr;
    if (xfer)
    begin
      h = stop ? a[7] : a[8];
      if (!split)
      begin
        for (i = 0; i < 256; i++) serial_access_memory[i] = {row[6:0], h, 8'(i)};
        ptr = stop ? {a[8], a[6:0]} : a[7:0];
        pend = 1'b0;
      end
      else
      begin
        for (i = 0; i < 128; i++) serial_access_memory[{~ptr[7], 7'(i)}] = {row[6:0], h, ~ptr[7], 7'(i)};
        nxt = {~ptr[7], a[6:0]};
        pend = 1'b1;
      end
      xfer = 1'b0;
    end
  end
  always @(posedge serial_shift_clock)
  begin
    q = serial_access_memory[ptr];
    if (pend && (ptr[6:0] == 7'h7f || stop && (ptr[6:0] & mask) == mask))
    begin
      ptr = nxt;
      pend = 1'b0;
    end
    else
      ptr = ptr + 8'h01;
  end
  assign serial_data = serial_output_enable_n ? ~q : q;
  assign active_half_flag = ptr[7];
endmodule : vrc_vram_model
